// *** rtl/pas_pkg.sv ***
package pas_pkg;
  // Register byte offsets (word aligned).
  localparam logic [7:0] PAS_OFS_CTRL = 8'h00;
  localparam logic [7:0] PAS_OFS_SRC = 8'h04;
  localparam logic [7:0] PAS_OFS_LVL = 8'h08;
  localparam logic [7:0] PAS_OFS_IRQ_STAT = 8'h0c;
  localparam logic [7:0] PAS_OFS_IRQ_MASK = 8'h10;
  localparam logic [7:0] PAS_OFS_STATUS = 8'h14;
  // Control register bit positions.
  localparam int PAS_CTRL_EN = 7;
  localparam int PAS_CTRL_STAT = 6;
  localparam int PAS_CTRL_OVR = 5;
  localparam int PAS_CTRL_ARS = 4;
  // Source register bit positions.
  localparam int PAS_SRC_PIN = 7;
  localparam int PAS_SRC_CMP_LO = 1;
  localparam int PAS_SRC_CMP_HI = 4;
  localparam logic [7:0] PAS_SRC_MASK = 8'h9e;
  // Interrupt status bits.
  localparam int PAS_IRQ_SHUT = 0;
  localparam int PAS_IRQ_RESUME = 1;
  localparam int PAS_IRQ_W = 2;
  // Reset values.
  localparam logic [7:0] PAS_CTRL_RST = 8'h00;
  localparam logic [7:0] PAS_SRC_RST = 8'h00;
  localparam logic [7:0] PAS_LVL_RST = 8'h00;
  // Output stage states.
  typedef enum logic [2:0] {
    PAS_RUN = 3'b001,
    PAS_SHUT = 3'b010,
    PAS_WAIT = 3'b100
  } pas_state_e;
endpackage : pas_pkg

// *** rtl/pas_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
// Two flip-flop synchroniser for a vector of asynchronous levels.
module pas_sync #(
  parameter int W = 5
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] meta_q;

  // The first stage is read only by the second stage.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      dout <= '0;
    end else begin
      meta_q <= din;
      dout <= meta_q;
    end
  end
endmodule : pas_sync
`default_nettype wire

// *** rtl/pas_apb_slave.sv ***
`timescale 1ns/1ps
`default_nettype none
// Zero wait state APB slave front end; pready is always high.
module pas_apb_slave (
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  output logic pready,
  output logic pslverr,
  output logic wrEn,
  output logic rdEn
);
  // Writes take effect in the access phase. Read data is fetched in the setup phase so that
  // the registered read data already stands at the access edge with no wait state.
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign wrEn = psel & penable & pwrite;
  assign rdEn = psel & ~penable & ~pwrite;
endmodule : pas_apb_slave
`default_nettype wire

// *** rtl/pas_auto_shutdown.sv ***
// The implementer's own choices: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// R1: Enable bit gates every shutdown feature.
// R2: Software setting status bit forces override.
// R3: Selected high source sets status, interrupt.
// R4: Sources are level sensitive, persist while high.
// R5: Shutdown drives programmed level per pin.
// R6: Override enable forces levels, no interrupt.
// R7: Restart-enable bit selects manual or automatic.
// R8: Manual: sticky until cleared, resume at period.
// R9: Auto: status clears when source drops.
// R10: Auto: resume at next period event.
// R11: Clear ignored while condition still present.
// R12: Source bit 7 selects external input pin.
// R13: Source bits 4..1 select comparators 4..1.
// R14: Request and status share one bit.
module pas_auto_shutdown
  import pas_pkg::*;
#(
  parameter int NPINS = 8
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic externalShutdownInput,
  input wire logic [4:1] comparatorOut,
  input wire logic periodEvent,
  input wire logic [NPINS-1:0] pwmIn,
  output logic [NPINS-1:0] pwmOut,
  output logic overrideActive,
  output logic irq
);
  logic rstSync1_q, rst_n;
  logic [4:0] srcSync;
  logic wrEn, rdEn;
  logic [7:0] ctrl_q, src_q;
  logic [NPINS-1:0] lvl_q;
  logic status_q, status_d;
  logic [PAS_IRQ_W-1:0] irqStat_q, irqMask_q, irqSet;
  pas_state_e state_q, state_d;
  logic enable, condition, swClr, swSet, overrideOn;
  logic [NPINS-1:0] pwmOut_q;

  // Reset is released through two flops so all logic leaves reset together.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rstSync1_q <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rstSync1_q <= 1'b1;
      rst_n <= rstSync1_q;
    end
  end

  // Pin and comparator levels are asynchronous to clk.
  pas_sync #(.W(5)) uSync (
    .clk(clk),
    .rst_n(rst_n),
    .din({externalShutdownInput, comparatorOut}),
    .dout(srcSync)
  );

  pas_apb_slave uApb (
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .pready(pready),
    .pslverr(pslverr),
    .wrEn(wrEn),
    .rdEn(rdEn)
  );

  // Combine the selected hardware sources; level evaluation, never edges.
  assign enable = ctrl_q[PAS_CTRL_EN]; // R1
  assign condition = enable & ( // R4
    (src_q[PAS_SRC_PIN] & srcSync[4]) | // R12
    (|(src_q[PAS_SRC_CMP_HI:PAS_SRC_CMP_LO] & srcSync[3:0]))); // R13

  // Software writes to the control register's status bit.
  assign swSet = wrEn && paddr == PAS_OFS_CTRL && pwdata[PAS_CTRL_STAT]; // R2
  assign swClr = wrEn && paddr == PAS_OFS_CTRL && !pwdata[PAS_CTRL_STAT];

  // One status bit, set by software or hardware; a set beats a clear.
  always_comb begin
    status_d = status_q;
    if (!enable) begin
      status_d = 1'b0; // R1
    end else if (condition || swSet) begin
      status_d = 1'b1; // R3 R14
    end else if (swClr) begin
      status_d = 1'b0; // R8 R11
    end else if (ctrl_q[PAS_CTRL_ARS] && state_q == PAS_SHUT && !swSet) begin
      // Auto restart drops the bit once the condition has gone.
      status_d = 1'b0; // R7 R9
    end
  end

  // Auto restart applies only to hardware-caused shutdowns; a software set
  // with no source would otherwise clear itself two cycles later.
  logic hwCause_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hwCause_q <= 1'b0;
    end else if (condition) begin
      hwCause_q <= 1'b1;
    end else if (!status_q) begin
      hwCause_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      status_q <= 1'b0;
    end else if (ctrl_q[PAS_CTRL_ARS] && !hwCause_q && !condition && !swClr && enable) begin
      status_q <= status_q | swSet;
    end else begin
      status_q <= status_d;
    end
  end

  // Output state: shutdown holds until status clears, then waits for period.
  always_comb begin
    state_d = state_q;
    case (state_q)
      PAS_RUN: begin
        if (status_q) state_d = PAS_SHUT;
      end
      PAS_SHUT: begin
        if (!status_q) state_d = PAS_WAIT;
      end
      PAS_WAIT: begin
        if (status_q) state_d = PAS_SHUT;
        else if (periodEvent) state_d = PAS_RUN; // R8 R10
      end
      default: state_d = PAS_RUN;
    endcase
    if (!enable) state_d = PAS_RUN; // R1
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= PAS_RUN;
    end else begin
      state_q <= state_d;
    end
  end

  // Control, source, level and mask registers.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= PAS_CTRL_RST;
      src_q <= PAS_SRC_RST;
      lvl_q <= '0;
      irqMask_q <= '0;
    end else if (wrEn) begin
      if (paddr == PAS_OFS_CTRL) begin
        ctrl_q <= pwdata[7:0];
      end else if (paddr == PAS_OFS_SRC) begin
        src_q <= pwdata[7:0] & PAS_SRC_MASK;
      end else if (paddr == PAS_OFS_LVL) begin
        lvl_q <= pwdata[NPINS-1:0];
      end else if (paddr == PAS_OFS_IRQ_MASK) begin
        irqMask_q <= pwdata[PAS_IRQ_W-1:0];
      end
    end
  end

  // Sticky events: entry to shutdown by status, and resume of normal output.
  assign irqSet[PAS_IRQ_SHUT] = status_d & ~status_q; // R3
  assign irqSet[PAS_IRQ_RESUME] = (state_q != PAS_RUN) && (state_d == PAS_RUN) && enable;

  // Write one to clear; a new event in the same cycle wins.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irqStat_q <= '0;
    end else if (wrEn && paddr == PAS_OFS_IRQ_STAT) begin
      irqStat_q <= (irqStat_q & ~pwdata[PAS_IRQ_W-1:0]) | irqSet;
    end else begin
      irqStat_q <= irqStat_q | irqSet;
    end
  end

  assign irq = |(irqStat_q & irqMask_q);

  // The override enable forces levels without touching status or interrupt.
  assign overrideOn = enable && (state_q != PAS_RUN || ctrl_q[PAS_CTRL_OVR]); // R6

  // Output pins come from a flop to keep glitches off the power stage.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pwmOut_q <= '0;
    end else if (overrideOn) begin
      pwmOut_q <= lvl_q; // R5
    end else begin
      pwmOut_q <= pwmIn;
    end
  end

  assign pwmOut = pwmOut_q;
  assign overrideActive = overrideOn;

  // Read mux; unmapped addresses read zero.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= '0;
    end else if (rdEn) begin
      if (paddr == PAS_OFS_CTRL) begin
        prdata <= {24'h0, ctrl_q[7], status_q, ctrl_q[5:0]};
      end else if (paddr == PAS_OFS_SRC) begin
        prdata <= {24'h0, src_q};
      end else if (paddr == PAS_OFS_LVL) begin
        prdata <= 32'(lvl_q);
      end else if (paddr == PAS_OFS_IRQ_STAT) begin
        prdata <= 32'(irqStat_q);
      end else if (paddr == PAS_OFS_IRQ_MASK) begin
        prdata <= 32'(irqMask_q);
      end else if (paddr == PAS_OFS_STATUS) begin
        prdata <= {27'h0, srcSync};
      end else begin
        prdata <= '0;
      end
    end
  end
endmodule : pas_auto_shutdown
`default_nettype wire

// *** test/pas_properties.sv ***
`timescale 1ns/1ps
`default_nettype none
// Port checks; control shadows follow the APB writes that the slave takes.
module pas_properties
  import pas_pkg::*;
#(
  parameter int NPINS = 8
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic externalShutdownInput,
  input wire logic [4:1] comparatorOut,
  input wire logic periodEvent,
  input wire logic [NPINS-1:0] pwmIn,
  input wire logic [NPINS-1:0] pwmOut,
  input wire logic overrideActive
);
  logic [7:0] ctrl_q, src_q;
  logic [NPINS-1:0] lvl_q;
  logic wr;
  assign wr = psel && penable && pwrite;
  // Shadows load at the access edge, the same edge the slave uses.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_q <= 8'h00;
      src_q <= 8'h00;
      lvl_q <= '0;
    end else if (wr) begin
      if (paddr == PAS_OFS_CTRL) ctrl_q <= pwdata[7:0];
      if (paddr == PAS_OFS_SRC) src_q <= pwdata[7:0];
      if (paddr == PAS_OFS_LVL) lvl_q <= pwdata[NPINS-1:0];
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  property p_off; !ctrl_q[7] [*2] |-> !overrideActive; endproperty
  a_off: assert property (p_off) else $error("override while disabled");
  property p_pin; (ctrl_q[7] && src_q[7] && externalShutdownInput) [*6] |-> overrideActive; endproperty
  a_pin: assert property (p_pin) else $error("pin level ignored");
  property p_cmp; (ctrl_q[7] && |(src_q[4:1] & comparatorOut)) [*6] |-> overrideActive; endproperty
  a_cmp: assert property (p_cmp) else $error("comparator ignored");
  property p_lvl; overrideActive [*4] |-> pwmOut == lvl_q; endproperty
  a_lvl: assert property (p_lvl) else $error("pins not at override level");
  property p_run; !overrideActive [*3] |-> pwmOut == $past(pwmIn); endproperty
  a_run: assert property (p_run) else $error("pins not following input");
  // Only a period event may end a shutdown while the block stays enabled.
  property p_res;
    $fell(overrideActive) && ctrl_q[7] && !$past(ctrl_q[5]) |-> $past(periodEvent);
  endproperty
  a_res: assert property (p_res) else $error("resume off the period event");
  property p_ovr; (ctrl_q[7] && ctrl_q[5]) [*2] |-> overrideActive; endproperty
  a_ovr: assert property (p_ovr) else $error("pin override ignored");
  property p_sw; wr && paddr == PAS_OFS_CTRL && pwdata[7:6] == 2'b11 |=> ##[0:2] overrideActive; endproperty
  a_sw: assert property (p_sw) else $error("software shutdown ignored");
  c_pin: cover property (src_q[7] && externalShutdownInput && overrideActive);
  c_cmp: cover property (|(src_q[4:1] & comparatorOut) && overrideActive);
  c_res: cover property ($fell(overrideActive));
endmodule // pas_properties
bind pas_auto_shutdown pas_properties #(.NPINS(NPINS)) u_props (.clk(clk), .arst_n(arst_n),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .externalShutdownInput(externalShutdownInput), .comparatorOut(comparatorOut),
  .periodEvent(periodEvent), .pwmIn(pwmIn), .pwmOut(pwmOut), .overrideActive(overrideActive));
`default_nettype wire

// *** test/pas_src_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// Shutdown sources; levels move just after an edge and then hold.
module pas_src_model (
  input wire logic clk,
  input wire logic pinReq,
  input wire logic [4:1] cmpReq,
  output logic pinOut,
  output logic [4:1] cmpOut
);
  // Levels, not edges, so a held request keeps the condition present.
  always_ff @(posedge clk) begin
    pinOut <= pinReq;
    cmpOut <= cmpReq;
  end
endmodule // pas_src_model
`default_nettype wire

// *** test/test_pas_auto_shutdown.sv ***
`timescale 1ns/1ps
`default_nettype none
module test_pas_auto_shutdown;
  import pas_pkg::*;
  logic clk, arst_n, psel, penable, pwrite, pready, ovr, irq, per, pinReq, pinS;
  logic ovrRaw, irqRaw, pslverr;
  logic [7:0] paddr, pwmIn, pwmOut, pwmRaw;
  logic [31:0] pwdata, prdata, r;
  logic [4:1] cmpReq, cmpS;
  int num_errors = 0, total_checks = 0, cyc = 0;
  pas_auto_shutdown u_dut (.clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .externalShutdownInput(pinS), .comparatorOut(cmpS), .periodEvent(per),
    .pwmIn(pwmIn), .pwmOut(pwmRaw), .overrideActive(ovrRaw), .irq(irqRaw));
  // Outputs are looked at mid-cycle, where they have settled after the edge.
  always @(negedge clk) begin
    ovr <= ovrRaw;
    irq <= irqRaw;
    pwmOut <= pwmRaw;
  end
  pas_src_model u_src (.clk(clk), .pinReq(pinReq), .cmpReq(cmpReq), .pinOut(pinS), .cmpOut(cmpS));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic end_of_test;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // A hang counts as a mismatch; the run needs well under a thousand cycles.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      num_errors++;
      end_of_test;
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask
  // One APB transfer; a read compares d with data registered at the end of the setup phase.
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= w ? d : 32'h0;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    r = prdata;
    chk(pslverr, 0);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
    if (!w) chk(r, d);
  endtask
  task automatic pulse;
    @(posedge clk);
    per <= 1'b1;
    @(posedge clk);
    per <= 1'b0;
    wt(3);
  endtask
  initial begin
    {arst_n, psel, penable, pwrite, per, pinReq, cmpReq, pwmIn, paddr, pwdata} = '0;
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    wt(3);
    pwmIn <= 8'h3c;
    apb(PAS_OFS_CTRL, 0, 0);
    apb(8'h18, 0, 0);
    apb(PAS_OFS_SRC, 1, 32'hff);
    apb(PAS_OFS_SRC, 0, 32'h9e);
    apb(PAS_OFS_LVL, 1, 32'ha5);
    apb(PAS_OFS_SRC, 1, 32'h80);
    pinReq <= 1'b1;
    wt(8);
    chk(ovr, 0);
    apb(PAS_OFS_CTRL, 1, 32'h80);
    wt(8);
    chk(pwmOut, 8'ha5);
    chk(irq, 0);
    apb(PAS_OFS_IRQ_MASK, 1, 32'h1);
    chk(irq, 1);
    apb(PAS_OFS_CTRL, 1, 32'h80);
    apb(PAS_OFS_CTRL, 0, 32'hc0);
    pinReq <= 1'b0;
    wt(8);
    apb(PAS_OFS_CTRL, 0, 32'hc0);
    apb(PAS_OFS_CTRL, 1, 32'h80);
    chk(ovr, 1);
    pulse;
    chk(pwmOut, 8'h3c);
    apb(PAS_OFS_IRQ_STAT, 1, 32'h3);
    chk(irq, 0);
    // Each comparator alone, with automatic restart.
    for (int i = 1; i <= 4; i++) begin
      apb(PAS_OFS_SRC, 1, 32'h1 << i);
      apb(PAS_OFS_CTRL, 1, 32'h90);
      cmpReq[i] <= 1'b1;
      wt(8);
      chk(ovr, 1);
      cmpReq[i] <= 1'b0;
      wt(8);
      apb(PAS_OFS_CTRL, 0, 32'h90);
      chk(ovr, 1);
      pulse;
      chk(ovr, 0);
    end
    apb(PAS_OFS_IRQ_STAT, 1, 32'h3);
    apb(PAS_OFS_CTRL, 1, 32'ha0);
    chk(ovr, 1);
    chk(irq, 0);
    apb(PAS_OFS_CTRL, 1, 32'hc0);
    wt(3);
    chk(ovr, 1);
    chk(irq, 1);
    apb(PAS_OFS_CTRL, 1, 32'h00);
    wt(2);
    chk(ovr, 0);
    end_of_test;
  end
endmodule // test_pas_auto_shutdown
`default_nettype wire
